// *** uart_mp_pkg.sv ***
// constants for the multiprocessor serial port
package uart_mp_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h98;
  localparam logic [7:0] DATA_ADDR      = 8'h99;
  localparam logic [7:0] CTRL_RESET     = 8'h40;
  localparam logic [7:0] DATA_RESET     = 8'h00;
  localparam int         BIT_MODE       = 7;
  localparam int         BIT_UNUSED     = 6;
  localparam int         BIT_MPE        = 5;
  localparam int         BIT_REN        = 4;
  localparam int         BIT_TB9        = 3;
  localparam int         BIT_RB9        = 2;
  localparam int         BIT_TI         = 1;
  localparam int         BIT_RI         = 0;
  localparam logic [3:0] DATA_BITS      = 4'h8;
  localparam logic [7:0] RELOAD_RESET   = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_NINTH = 3'b010,
    ST_STOP  = 3'b110
  } frame_state_e;
endpackage

// *** uart_mp_baud.sv ***
// 8-bit auto-reload timer giving one tick per two overflows
`timescale 1ns/100ps
module uart_mp_baud
  import uart_mp_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  // control
  input  wire logic       TICK_IN,
  input  wire logic [7:0] RELOAD,
  input  wire logic       FORCE_RELOAD,
  // output
  output logic            BAUD_TICK
);
  logic [7:0] count;
  logic       half;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= RELOAD_RESET;
      half  <= 1'b0;
    end else if (CE) begin
      if (FORCE_RELOAD) begin
        // forced reload ticks after one overflow, so samples land mid-bit
        count <= RELOAD;
        half  <= 1'b1;
      end else if (TICK_IN) begin
        if (count == 8'hFF) begin
          count <= RELOAD;
          half  <= ~half;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

  assign BAUD_TICK = CE && !FORCE_RELOAD && TICK_IN && (count == 8'hFF) && half;
endmodule // uart_mp_baud

// *** uart_mp_port.sv ***
// multiprocessor serial port with control and data buffer registers
// How it works
// - address byte ninth bit 1, data 0
// - nine-bit with enable: accept only ninth=1
// - control bit 7 selects 8/9-bit framing
// - eight-bit with enable: accept only stop=1
// - control bit 6 reads 1, ignores writes
// - control bit 4 enables the receiver
// - nine-bit transmit sends control bit 3
// - bit 2 takes stop or ninth bit
// - tx flag set at stop start, software clears
// - rx flag set at stop sample, software clears
// - either flag raises interrupt while enabled
// - data write loads shifter and starts sending
// - data read returns receive latch
// - bit rate is half timer overflow rate
// - 8-bit frame: start, 8 LSB-first, stop
// - 9-bit frame adds ninth; stop ignored
// - store only if flag clear and condition
`timescale 1ns/100ps
module uart_mp_port
  import uart_mp_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  // register bus
  input  wire logic [7:0] ADDR,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  // baud timer
  input  wire logic       TIMER_TICK,
  input  wire logic [7:0] TIMER_RELOAD,
  // interrupt
  input  wire logic       INT_ENABLE,
  output logic            INT_REQ,
  // serial line
  input  wire logic       RX,
  output logic            TX
);
  logic         frame_mode_select, multiproc_enable, receiver_enable;
  logic         tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag;
  logic [7:0]   rx_latch;
  logic         rx_meta, rx_sync, rx_prev;
  frame_state_e tx_state, rx_state;
  logic [7:0]   tx_shift, rx_shift;
  logic [3:0]   tx_cnt, rx_cnt;
  logic         rx_ninth_got;
  logic         tx_tick, rx_tick, rx_start;
  logic         wr_ctrl, wr_data, tx_set, rx_accept;
  logic         rx_cond;

  assign wr_ctrl = WR && (ADDR == CTRL_ADDR);
  assign wr_data = WR && (ADDR == DATA_ADDR);

  // rx pin synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else if (CE) begin
      rx_meta <= RX;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_start = receiver_enable && (rx_state == ST_IDLE) && rx_prev && !rx_sync;

  uart_mp_baud tx_baud (
    .CLK          (CLK),
    .RST_N        (RST_N),
    .CE           (CE),
    .TICK_IN      (TIMER_TICK),
    .RELOAD       (TIMER_RELOAD),
    .FORCE_RELOAD (1'b0),
    .BAUD_TICK    (tx_tick)
  );

  uart_mp_baud rx_baud (
    .CLK          (CLK),
    .RST_N        (RST_N),
    .CE           (CE),
    .TICK_IN      (TIMER_TICK),
    .RELOAD       (TIMER_RELOAD),
    .FORCE_RELOAD (rx_start),
    .BAUD_TICK    (rx_tick)
  );

  // transmitter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_state <= ST_IDLE;
      tx_shift <= DATA_RESET;
      tx_cnt   <= 4'h0;
      TX       <= 1'b1;
    end else if (CE) begin
      if (wr_data) begin
        tx_shift <= WDATA;
        tx_state <= ST_START;
        tx_cnt   <= 4'h0;
      end else if (tx_tick) begin
        case (tx_state)
          ST_START: begin
            TX       <= 1'b0;
            tx_state <= ST_DATA;
          end
          ST_DATA: begin
            TX       <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_cnt   <= tx_cnt + 4'h1;
            if (tx_cnt == DATA_BITS - 4'h1) begin
              tx_state <= frame_mode_select ? ST_NINTH : ST_STOP;
            end
          end
          ST_NINTH: begin
            TX       <= tx_ninth_bit;
            tx_state <= ST_STOP;
          end
          ST_STOP: begin
            TX       <= 1'b1;
            tx_state <= ST_IDLE;
          end
          default: begin
            TX       <= 1'b1;
            tx_state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign tx_set = CE && !wr_data && tx_tick && (tx_state == ST_STOP);

  // receiver
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_state     <= ST_IDLE;
      rx_shift     <= DATA_RESET;
      rx_cnt       <= 4'h0;
      rx_ninth_got <= 1'b0;
    end else if (CE) begin
      if (rx_start) begin
        rx_state <= ST_START;
        rx_cnt   <= 4'h0;
      end else if (!receiver_enable) begin
        rx_state <= ST_IDLE;
      end else if (rx_tick) begin
        // one tick per bit, each at mid-bit after the forced reload
        case (rx_state)
          ST_START: begin
            // a start bit that is high again was a glitch
            if (rx_sync) begin
              rx_state <= ST_IDLE;
            end else begin
              rx_state <= ST_DATA;
            end
          end
          ST_DATA: begin
            rx_shift <= {rx_sync, rx_shift[7:1]};
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_cnt == DATA_BITS - 4'h1) begin
              rx_state <= frame_mode_select ? ST_NINTH : ST_STOP;
            end
          end
          ST_NINTH: begin
            rx_ninth_got <= rx_sync;
            rx_state     <= ST_STOP;
          end
          ST_STOP: begin
            rx_state <= ST_IDLE;
          end
          default: rx_state <= ST_IDLE;
        endcase
      end
    end
  end

  // stop-bit sampling time and acceptance check
  assign rx_cond = !multiproc_enable || (frame_mode_select ? rx_ninth_got : rx_sync);
  assign rx_accept = CE && receiver_enable && !rx_start && rx_tick
                     && (rx_state == ST_STOP) && !rx_done_flag && rx_cond;

  // control register and receive latch
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_mode_select <= CTRL_RESET[BIT_MODE];
      multiproc_enable  <= CTRL_RESET[BIT_MPE];
      receiver_enable   <= CTRL_RESET[BIT_REN];
      tx_ninth_bit      <= CTRL_RESET[BIT_TB9];
      rx_ninth_bit      <= CTRL_RESET[BIT_RB9];
      tx_done_flag      <= CTRL_RESET[BIT_TI];
      rx_done_flag      <= CTRL_RESET[BIT_RI];
      rx_latch          <= DATA_RESET;
    end else if (CE) begin
      if (wr_ctrl) begin
        frame_mode_select <= WDATA[BIT_MODE];
        multiproc_enable  <= WDATA[BIT_MPE];
        receiver_enable   <= WDATA[BIT_REN];
        tx_ninth_bit      <= WDATA[BIT_TB9];
        rx_ninth_bit      <= WDATA[BIT_RB9];
        tx_done_flag      <= WDATA[BIT_TI];
        rx_done_flag      <= WDATA[BIT_RI];
      end
      if (tx_set) begin
        tx_done_flag <= 1'b1;
      end
      if (rx_accept) begin
        rx_latch     <= rx_shift;
        rx_ninth_bit <= frame_mode_select ? rx_ninth_got : rx_sync;
        rx_done_flag <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    RDATA = 8'h00;
    if (RD && ADDR == CTRL_ADDR) begin
      RDATA = {frame_mode_select, 1'b1, multiproc_enable, receiver_enable,
               tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
    end else if (RD && ADDR == DATA_ADDR) begin
      RDATA = rx_latch;
    end
  end

  assign INT_REQ = INT_ENABLE && (tx_done_flag || rx_done_flag);
endmodule // uart_mp_port

// *** uart_mp_port_props.sv ***
// port checker for the multiprocessor serial port
`timescale 1ns/100ps
module uart_mp_port_props
  import uart_mp_pkg::*;
(
  // clock and reset
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CE,
  // register bus
  input wire logic [7:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // interrupt and line
  input wire logic       INT_ENABLE,
  input wire logic       INT_REQ,
  input wire logic       TX
);
  logic        ctrl_wr;
  logic        start_wait;
  logic [10:0] start_age;
  assign ctrl_wr = CE && WR && ADDR == CTRL_ADDR;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // cycles from a data write until the start bit shows, saturating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_wait <= 1'b0;
      start_age  <= 11'h000;
    end else if (CE && WR && ADDR == DATA_ADDR) begin
      start_wait <= 1'b1;
      start_age  <= 11'h000;
    end else if (!TX) begin
      start_wait <= 1'b0;
    end else if (CE && start_wait && start_age != 11'h7FF) begin
      start_age  <= start_age + 11'h001;
    end
  end
  property p_irq; INT_REQ |-> INT_ENABLE; endproperty
  a_irq: assert property (p_irq) else $error("irq while off");
  property p_b6; RD && ADDR == CTRL_ADDR |-> RDATA[BIT_UNUSED]; endproperty
  a_b6: assert property (p_b6) else $error("bit6 low");
  property p_unm; RD && ADDR != CTRL_ADDR && ADDR != DATA_ADDR |-> RDATA == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_rdz; !RD |-> RDATA == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata idle");
  property p_hold; $changed(TX) |=> $stable(TX); endproperty
  a_hold: assert property (p_hold) else $error("short bit");
  property p_start; start_wait |-> start_age < 11'h44C; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_stick; $fell(INT_REQ) && INT_ENABLE |-> $past(ctrl_wr); endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  property p_frz; !CE |=> $stable(TX); endproperty
  a_frz: assert property (p_frz) else $error("moved frozen");
endmodule // uart_mp_port_props
bind uart_mp_port uart_mp_port_props u_uart_mp_port_props (
  .CLK, .RST_N, .CE, .ADDR, .WR, .RD, .RDATA, .INT_ENABLE, .INT_REQ, .TX);

// *** uart_mp_node.sv ***
// remote serial node on the port's line
`timescale 1ns/100ps
module uart_mp_node #(
  parameter int BIT = 4
) (
  // clock
  input  wire logic CLK,
  // serial line
  input  wire logic LINE_IN,
  output logic      LINE_OUT
);
  initial LINE_OUT = 1'b1;
  // start, data lsb first, ninth or stop, stop, then idle
  task automatic send(input logic [7:0] d, input logic ext);
    logic [10:0] f;
    f = {1'b1, ext, d, 1'b0};
    repeat (13) begin
      @(negedge CLK);
      LINE_OUT = f[0];
      f = {1'b1, f[10:1]};
      repeat (BIT - 1) @(negedge CLK);
    end
  endtask
  task automatic recv(output logic [10:0] f);
    f = 11'h000;
    while (LINE_IN) @(negedge CLK);
    repeat (BIT / 2) @(negedge CLK);
    repeat (11) begin
      f = {LINE_IN, f[10:1]};
      repeat (BIT) @(negedge CLK);
    end
  endtask
endmodule // uart_mp_node

// *** uart_mp_port_tb.sv ***
// bench for the multiprocessor serial port
`timescale 1ns/100ps
module uart_mp_port_tb
  import uart_mp_pkg::*;
;
  localparam logic [7:0] RCW [7] = '{8'hB0, 8'hB0, 8'h90, 8'h30, 8'h10, 8'h00, 8'h11};
  localparam logic [6:0] EXT = 7'b1100010;
  localparam logic [6:0] ACC = 7'b0010110;
  logic        CLK = 1'b0, RST_N = 1'b0, CE = 1'b0, WR = 1'b0, RD = 1'b0;
  logic        INT_REQ, TX, RX, INT_ENABLE = 1'b1;
  logic [7:0]  TIMER_RELOAD = 8'hFE;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RDATA, c, rxd = 8'h00;
  logic [10:0] f;
  int          fails = 0, num_checks = 0;
  int          n = 0;
  always #2 CLK = ~CLK;
  uart_mp_port u_uart_mp_port (.CLK, .RST_N, .CE, .ADDR, .WR, .RD, .WDATA, .RDATA,
    .TIMER_TICK(1'b1), .TIMER_RELOAD, .INT_ENABLE, .INT_REQ, .RX, .TX);
  uart_mp_node u_uart_mp_node (.CLK, .LINE_IN(TX), .LINE_OUT(RX));
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle: write d, or read and compare with d
  task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    {WR, RD, ADDR, WDATA} = {w, ~w, a, d};
    @(posedge CLK);
    if (!w) chk({3'h0, RDATA}, {3'h0, d});
    @(negedge CLK);
    {WR, RD} = 2'b00;
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge CLK);
    RST_N = 1'b1;
    repeat (2) @(negedge CLK);
    CE = 1'b1;
    io(1'b0, CTRL_ADDR, CTRL_RESET);
    io(1'b0, DATA_ADDR, DATA_RESET);
    io(1'b1, CTRL_ADDR, 8'h00);
    io(1'b0, CTRL_ADDR, 8'h40);
    io(1'b0, 8'h9A, 8'h00);
    $display("registers done");
    for (int m = 0; m < 3; m++) begin
      c = m == 0 ? 8'h00 : {4'h8, m == 1, 3'h0};
      io(1'b1, CTRL_ADDR, c);
      fork
        u_uart_mp_node.recv(f);
        io(1'b1, DATA_ADDR, 8'hA5 ^ c);
      join
      chk(f, {1'b1, m != 2, 8'hA5 ^ c, 1'b0});
      io(1'b0, CTRL_ADDR, c | 8'h42);
      chk({10'h000, INT_REQ}, 11'h001);
    end
    INT_ENABLE = 1'b0;
    @(negedge CLK);
    chk({10'h000, INT_REQ}, 11'h000);
    INT_ENABLE = 1'b1;
    io(1'b0, DATA_ADDR, 8'h00);
    $display("transmit done");
    // slow reload: a bit lasts two overflows of 256 - 0xCB timer clocks
    TIMER_RELOAD = 8'hCB;
    io(1'b1, CTRL_ADDR, 8'h00);
    repeat (10) @(negedge CLK);
    io(1'b1, DATA_ADDR, 8'h55);
    while (TX) @(negedge CLK);
    n = 0;
    while (!TX) begin
      @(negedge CLK);
      n++;
    end
    chk(n[10:0], 11'h06A);
    // frozen clock enable keeps the high first data bit on the line
    CE = 1'b0;
    repeat (200) @(negedge CLK);
    chk({10'h000, TX}, 11'h001);
    CE = 1'b1;
    repeat (1000) @(negedge CLK);
    io(1'b0, CTRL_ADDR, 8'h42);
    TIMER_RELOAD = 8'hFE;
    $display("timing done");
    for (int i = 0; i < 7; i++) begin
      io(1'b1, CTRL_ADDR, RCW[i]);
      u_uart_mp_node.send(8'h30 + i[7:0], EXT[i]);
      if (ACC[i]) rxd = 8'h30 + i[7:0];
      io(1'b0, DATA_ADDR, rxd);
      io(1'b0, CTRL_ADDR, RCW[i] | {5'h08, ACC[i] & EXT[i], 1'b0, ACC[i] | RCW[i][0]});
      chk({10'h000, INT_REQ}, {10'h000, ACC[i] | RCW[i][0]});
    end
    $display("receive done");
    conclude;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    fails++;
    conclude;
  end
endmodule // uart_mp_port_tb
